// ---- logic/aia_top.sv ----
// alarm interrupt aggregator: sticky alarms, enables, global irq, gpi mirror
// Functional notes
// RL1: the lock-loss sticky bit reaches the interrupt only while its enable is 1 (reset 0).
// RL2: each reference signal-loss sticky bit has its own enable, reset 0, gating the interrupt.
// RL3: a raised lock-loss or reference signal-loss alarm sets its sticky bit.
// RL4: a sticky bit stays 1 after its alarm has gone away.
// RL5: a sticky bit clears only when the host writes 1 to it; writing 0 keeps it.
// RL6: the lock-loss sticky bit shows whether any lock loss happened since the last clear.
// RL7: each reference sticky bit shows any signal loss on it since the last clear.
// RL8: enables sit at 0079: ref0 in bit 0, ref1 in bit 1, lock loss in bit 6.
// RL9: sticky bits sit at 0200: ref0 in D0, ref1 in D1, lock loss in D6; 0201 is reserved.
// RL10: byte 020C returns in its low four bits the levels of pins set as inputs.
// RL11: the global bit is the OR of enabled sticky bits and pulls the interrupt pin low.
// RL12: the host writes zero to reserved bits; reserved bits read back as zero here.
// RL13: a set and a clear in the same cycle leave the sticky bit set.
// RL14: the interrupt pin is registered, one cycle after any sticky or enable change.
`timescale 1ns/1ps
module aia_top #(
   parameter int GPI_W = aia_pkg::GPI_W
) (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [aia_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic                      reg_wr,
   input  wire logic [aia_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                      reg_rd,
   output logic      [aia_pkg::DATA_W-1:0] reg_rdata_ff,
   output logic                           reg_rvalid_ff,
   input  wire logic                      lock_loss,
   input  wire logic [1:0]                signal_loss,
   input  wire logic [GPI_W-1:0]          gpio_level,
   input  wire logic [GPI_W-1:0]          gpio_is_input,
   output logic                           global_irq_ff,
   output logic                           irq_pin_low_o_ff,
   output logic                           irq_pin_low_oe_ff
);
   typedef struct packed {
      logic                        lock_en;
      logic [1:0]                  ref_sigloss_irq_enable;
      logic [aia_pkg::DATA_W-1:0]  rdata;
      logic                        rvalid;
      logic                        global_irq;
      logic                        pin_out;
      logic                        pin_oe;
   } aia_state_t;

   aia_state_t                   st_ff;
   aia_state_t                   nxt_st;
   logic [aia_pkg::ALARM_N-1:0]  sticky;
   logic [aia_pkg::ALARM_N-1:0]  alarm_set;
   logic [aia_pkg::ALARM_N-1:0]  w1c;
   logic [aia_pkg::ALARM_N-1:0]  en_vec;
   logic                         wr_status;
   logic [aia_pkg::DATA_W-1:0]   rd_mux;

   // alarms are levels; holding one high keeps re-setting the flag
   assign alarm_set[aia_pkg::IDX_REF0] = signal_loss[0]; // RL3
   assign alarm_set[aia_pkg::IDX_REF1] = signal_loss[1]; // RL3
   assign alarm_set[aia_pkg::IDX_LOCK] = lock_loss;      // RL3

   // write-one clear strobes from the status byte
   assign wr_status = reg_wr && (reg_addr == aia_pkg::ADDR_STICKY);
   assign w1c[aia_pkg::IDX_REF0] = wr_status & reg_wdata[aia_pkg::BIT_REF0]; // RL5
   assign w1c[aia_pkg::IDX_REF1] = wr_status & reg_wdata[aia_pkg::BIT_REF1]; // RL5
   assign w1c[aia_pkg::IDX_LOCK] = wr_status & reg_wdata[aia_pkg::BIT_LOCK]; // RL5

   aia_sticky_bits #(
      .N      (aia_pkg::ALARM_N)
   ) u_sticky (
      .clk    (clk),
      .rst_n  (rst_n),
      .set_in (alarm_set),
      .clr_in (w1c),
      .flags  (sticky)
   );

   // enable vector in sticky order
   assign en_vec = {st_ff.lock_en, st_ff.ref_sigloss_irq_enable};

   // read data; reserved bits and unmapped addresses read zero
   always_comb
   begin
      rd_mux = aia_pkg::RST_BYTE;
      unique case (reg_addr)
         aia_pkg::ADDR_IRQ_EN:
         begin
            rd_mux[aia_pkg::BIT_REF0] = st_ff.ref_sigloss_irq_enable[0]; // RL8
            rd_mux[aia_pkg::BIT_REF1] = st_ff.ref_sigloss_irq_enable[1]; // RL8
            rd_mux[aia_pkg::BIT_LOCK] = st_ff.lock_en;                  // RL8
         end
         aia_pkg::ADDR_FACTORY_A:
            rd_mux = aia_pkg::RST_FACTORY_A;
         aia_pkg::ADDR_STICKY:
         begin
            rd_mux[aia_pkg::BIT_REF0] = sticky[aia_pkg::IDX_REF0]; // RL9
            rd_mux[aia_pkg::BIT_REF1] = sticky[aia_pkg::IDX_REF1]; // RL9
            rd_mux[aia_pkg::BIT_LOCK] = sticky[aia_pkg::IDX_LOCK]; // RL9
         end
         aia_pkg::ADDR_GPI:
            rd_mux[GPI_W-1:0] = gpio_level & gpio_is_input; // RL10
         default:
            rd_mux = aia_pkg::RST_BYTE; // RL12
      endcase
   end

   // next state: enable writes, read capture, irq aggregation
   always_comb
   begin
      nxt_st = st_ff;
      if (reg_wr && (reg_addr == aia_pkg::ADDR_IRQ_EN))
      begin
         // reserved bits of the enable byte are not stored
         nxt_st.ref_sigloss_irq_enable[0] = reg_wdata[aia_pkg::BIT_REF0]; // RL2 RL8
         nxt_st.ref_sigloss_irq_enable[1] = reg_wdata[aia_pkg::BIT_REF1]; // RL2 RL8
         nxt_st.lock_en                   = reg_wdata[aia_pkg::BIT_LOCK]; // RL1 RL8
      end
      nxt_st.rvalid = reg_rd;
      if (reg_rd)
         nxt_st.rdata = rd_mux;
      // registered so the pin never glitches on a mux change
      nxt_st.global_irq = |(sticky & en_vec); // RL1 RL2 RL11 RL14
      nxt_st.pin_oe     = |(sticky & en_vec); // RL11 RL14
      nxt_st.pin_out    = 1'b0;               // open drain only pulls low
   end

   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff.lock_en                <= aia_pkg::RST_ENABLES[aia_pkg::IDX_LOCK]; // RL1
         st_ff.ref_sigloss_irq_enable <= aia_pkg::RST_ENABLES[1:0];              // RL2
         st_ff.rdata                  <= aia_pkg::RST_BYTE;
         st_ff.rvalid                 <= 1'b0;
         st_ff.global_irq             <= 1'b0;
         st_ff.pin_out                <= 1'b0;
         st_ff.pin_oe                 <= 1'b0;
      end
      else
         st_ff <= nxt_st;
   end

   assign reg_rdata_ff      = st_ff.rdata;
   assign reg_rvalid_ff     = st_ff.rvalid;
   assign global_irq_ff     = st_ff.global_irq;
   assign irq_pin_low_o_ff  = st_ff.pin_out;
   assign irq_pin_low_oe_ff = st_ff.pin_oe;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // lock loss disabled never drives the pin by itself; gating taken field by field
   a_lock_mask: assert property ( // RL1
      (!st_ff.lock_en &&
       !(sticky[aia_pkg::IDX_REF0] && st_ff.ref_sigloss_irq_enable[0]) &&
       !(sticky[aia_pkg::IDX_REF1] && st_ff.ref_sigloss_irq_enable[1]))
      |=> (!irq_pin_low_oe_ff && !global_irq_ff))
      else $error("pin driven with no enabled sticky bit");

   // enabled ref1 flag drives the pin next cycle
   a_ref_enable: assert property ( // RL2
      (sticky[aia_pkg::IDX_REF1] && st_ff.ref_sigloss_irq_enable[1]) |=> irq_pin_low_oe_ff)
      else $error("enabled ref1 flag did not assert the pin");

   // alarm sets its flag, even against a clear
   a_alarm_sets: assert property ( // RL3
      lock_loss |=> sticky[aia_pkg::IDX_LOCK])
      else $error("lock-loss alarm did not set its flag");

   // flag holds when no clear is written
   a_flag_holds: assert property ( // RL4
      (sticky[aia_pkg::IDX_REF0] && !w1c[aia_pkg::IDX_REF0]) |=> sticky[aia_pkg::IDX_REF0])
      else $error("ref0 flag dropped without a clear");

   // write one clears when no alarm
   a_w1c_clear: assert property ( // RL5
      (wr_status && reg_wdata[aia_pkg::BIT_LOCK] && !lock_loss) |=> !sticky[aia_pkg::IDX_LOCK])
      else $error("write one did not clear lock-loss flag");

   // rise of a flag needs its alarm a cycle earlier
   a_rise_cause: assert property ( // RL6
      $rose(sticky[aia_pkg::IDX_LOCK]) |-> $past(lock_loss))
      else $error("lock-loss flag rose without an alarm");

   a_ref_cause: assert property ( // RL7
      $rose(sticky[aia_pkg::IDX_REF1]) |-> $past(signal_loss[1]))
      else $error("ref1 flag rose without an alarm");

   // enable write lands in the right bits
   a_en_write: assert property ( // RL8
      (reg_wr && reg_addr == aia_pkg::ADDR_IRQ_EN) |=>
         (st_ff.lock_en == $past(reg_wdata[aia_pkg::BIT_LOCK])) &&
         (st_ff.ref_sigloss_irq_enable == $past(reg_wdata[1:0])))
      else $error("enable write not stored");

   // status read layout and timing
   a_status_read: assert property ( // RL9
      (reg_rd && reg_addr == aia_pkg::ADDR_STICKY) |=> reg_rvalid_ff &&
         (reg_rdata_ff == {1'b0, $past(sticky[2]), 4'h0, $past(sticky[1:0])}))
      else $error("status byte read wrong");

   a_gpi_read: assert property ( // RL10
      (reg_rd && reg_addr == aia_pkg::ADDR_GPI) |=>
         (reg_rdata_ff == {4'h0, $past(gpio_level & gpio_is_input)}))
      else $error("gpi byte read wrong");

   // global bit and pin move together, one cycle after the cause
   a_global_pin: assert property ( // RL11 RL14
      ((sticky[aia_pkg::IDX_LOCK] && st_ff.lock_en) ||
       (sticky[aia_pkg::IDX_REF0] && st_ff.ref_sigloss_irq_enable[0]) ||
       (sticky[aia_pkg::IDX_REF1] && st_ff.ref_sigloss_irq_enable[1]))
      |=> (global_irq_ff && irq_pin_low_oe_ff && !irq_pin_low_o_ff))
      else $error("global bit or pin late");

   a_reserved_zero: assert property ( // RL12
      (reg_rd && reg_addr == aia_pkg::ADDR_STICKY_RSV) |=> (reg_rdata_ff == 8'h00))
      else $error("reserved byte not zero");
endmodule : aia_top

// ---- logic/aia_pkg.sv ----
// constants for the alarm interrupt aggregator
package aia_pkg;
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 8;
   localparam int          GPI_W           = 4;
   localparam int          ALARM_N         = 3;
   // register addresses
   localparam logic [15:0] ADDR_IRQ_EN     = 16'h0079;
   localparam logic [15:0] ADDR_FACTORY_A  = 16'h007A;
   localparam logic [15:0] ADDR_FACTORY_B  = 16'h007B;
   localparam logic [15:0] ADDR_STICKY     = 16'h0200;
   localparam logic [15:0] ADDR_STICKY_RSV = 16'h0201;
   localparam logic [15:0] ADDR_GPI        = 16'h020C;
   // field positions, shared by enable and status bytes
   localparam int          BIT_REF0        = 0;
   localparam int          BIT_REF1        = 1;
   localparam int          BIT_LOCK        = 6;
   // index of each source inside the sticky vector
   localparam int          IDX_REF0        = 0;
   localparam int          IDX_REF1        = 1;
   localparam int          IDX_LOCK        = 2;
   // reset values
   localparam logic [7:0]  RST_FACTORY_A   = 8'h27;
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [2:0]  RST_ENABLES     = 3'h0;
endpackage : aia_pkg

// ---- logic/aia_sticky_bits.sv ----
// write-one-to-clear sticky flags, set wins over clear
`timescale 1ns/1ps
module aia_sticky_bits #(
   parameter int N = 3
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [N-1:0] set_in,
   input  wire logic [N-1:0] clr_in,
   output logic      [N-1:0] flags
);
   typedef struct packed {
      logic [N-1:0] bits;
   } aia_sticky_t;

   aia_sticky_t st_ff;
   aia_sticky_t nxt_st;

   // per-bit next value; a set in the clear cycle is kept
   always_comb
   begin
      nxt_st = st_ff;
      for (int i = 0; i < N; i++)
      begin
         nxt_st.bits[i] = set_in[i] | (st_ff.bits[i] & ~clr_in[i]); // RL3 RL4 RL5 RL13
      end
   end

   // flags reset to zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_ff <= '0; // RL6 RL7
      else
         st_ff <= nxt_st;
   end

   assign flags = st_ff.bits;
endmodule : aia_sticky_bits

// ---- test/aia_host_model.sv ----
// host model issuing byte reads and writes on the register port
`timescale 1ns/1ps
module aia_host_model (
   input  wire logic        clk,
   output logic      [15:0] reg_addr,
   output logic             reg_wr,
   output logic      [7:0]  reg_wdata,
   output logic             reg_rd,
   input  wire logic [7:0]  reg_rdata_ff,
   input  wire logic        reg_rvalid_ff
);
   // idle bus at time zero
   initial
   begin
      reg_addr  = 16'h0000;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end

   // released lines show inverted values so stale data never looks valid
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   // strobe stands one edge only, else a second read is taken; data at the valid edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      ok = reg_rvalid_ff;
      d  = reg_rdata_ff;
      reg_addr <= ~a;
   endtask : rd
endmodule : aia_host_model

// ---- test/testbench.sv ----
// self-checking bench for the alarm interrupt aggregator
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] reg_addr;
   logic        reg_wr;
   logic [7:0]  reg_wdata;
   logic        reg_rd;
   logic [7:0]  reg_rdata_ff;
   logic        reg_rvalid_ff;
   logic        lock_loss = 1'b0;
   logic [1:0]  signal_loss = 2'h0;
   logic [3:0]  gpio_level = 4'hA;
   logic [3:0]  gpio_is_input = 4'hC;
   logic        global_irq_ff;
   logic        irq_pin_low_o_ff;
   logic        irq_pin_low_oe_ff;
   int          errors = 0;
   int          comparisons = 0;
   logic [7:0]  en_tab [3] = '{8'h01, 8'h02, 8'h40};

   always #10 clk = ~clk;

   aia_top u_aia_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .reg_rvalid_ff(reg_rvalid_ff), .lock_loss(lock_loss), .signal_loss(signal_loss),
      .gpio_level(gpio_level), .gpio_is_input(gpio_is_input), .global_irq_ff(global_irq_ff),
      .irq_pin_low_o_ff(irq_pin_low_o_ff), .irq_pin_low_oe_ff(irq_pin_low_oe_ff));

   aia_host_model u_aia_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .reg_rvalid_ff(reg_rvalid_ff));

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
      end
   endtask : chk_bit

   // a missing valid also counts, so a silent port cannot pass
   task automatic rd_expect(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      u_aia_host_model.rd(a, d, ok);
      chk_bit(ok, 1'b1);
      chk_byte(d, exp);
   endtask : rd_expect

   // pin is open drain: value stays 0, enable carries the interrupt
   task automatic irq_expect(input logic exp);
      chk_bit(global_irq_ff, exp);
      chk_bit(irq_pin_low_oe_ff, exp);
      chk_bit(irq_pin_low_o_ff, 1'b0);
   endtask : irq_expect

   task automatic print_verdict;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_expect(aia_pkg::ADDR_IRQ_EN, 8'h00);
      rd_expect(aia_pkg::ADDR_STICKY, 8'h00);
      irq_expect(1'b0);
      rd_expect(aia_pkg::ADDR_FACTORY_A, aia_pkg::RST_FACTORY_A);
      rd_expect(aia_pkg::ADDR_STICKY_RSV, 8'h00);
      rd_expect(16'h0300, 8'h00);
      rd_expect(aia_pkg::ADDR_GPI, 8'h08);
      @(posedge clk);
      gpio_level <= 4'h5;
      gpio_is_input <= 4'hF;
      rd_expect(aia_pkg::ADDR_GPI, 8'h05);
      // one-cycle alarm pulses on every source
      @(posedge clk);
      lock_loss <= 1'b1;
      signal_loss <= 2'h3;
      @(posedge clk);
      lock_loss <= 1'b0;
      signal_loss <= 2'h0;
      rd_expect(aia_pkg::ADDR_STICKY, 8'h43);
      irq_expect(1'b0);
      // each enable alone drives the pin, one cycle behind the write
      foreach (en_tab[i])
      begin
         u_aia_host_model.wr(aia_pkg::ADDR_IRQ_EN, en_tab[i]);
         #1;
         irq_expect(1'b0);
         @(posedge clk);
         #1;
         irq_expect(1'b1);
         rd_expect(aia_pkg::ADDR_IRQ_EN, en_tab[i]);
         u_aia_host_model.wr(aia_pkg::ADDR_IRQ_EN, 8'h00);
         @(posedge clk);
         #1;
         irq_expect(1'b0);
      end
      u_aia_host_model.wr(aia_pkg::ADDR_STICKY, 8'h00);
      rd_expect(aia_pkg::ADDR_STICKY, 8'h43);
      u_aia_host_model.wr(aia_pkg::ADDR_STICKY, 8'h41);
      rd_expect(aia_pkg::ADDR_STICKY, 8'h02);
      u_aia_host_model.wr(aia_pkg::ADDR_IRQ_EN, 8'h41);
      repeat (2) @(posedge clk);
      #1;
      irq_expect(1'b0);
      // clear lands while the alarm is still high
      @(posedge clk);
      lock_loss <= 1'b1;
      fork
         u_aia_host_model.wr(aia_pkg::ADDR_STICKY, 8'h40);
         begin
            repeat (2) @(posedge clk);
            lock_loss <= 1'b0;
         end
      join
      rd_expect(aia_pkg::ADDR_STICKY, 8'h42);
      irq_expect(1'b1);
      // second reset in mid-run, with flags and enables set: all must return to zero
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      irq_expect(1'b0);
      @(posedge clk);
      rst_n <= 1'b1;
      rd_expect(aia_pkg::ADDR_IRQ_EN, 8'h00);
      rd_expect(aia_pkg::ADDR_STICKY, 8'h00);
      irq_expect(1'b0);
      print_verdict();
   end
endmodule : testbench
